// ==== design/gpt_map.svh ====
// constants of the first timer module: widths, reset values, timing counts
`ifndef GPT_MAP_SVH
`define GPT_MAP_SVH

// width of each timer
`define GPT_TIMER_WIDTH      16
// number of timers in the first module
`define GPT_NUM_TIMERS       3
// timer index of each timer
`define GPT_IDX_AUX_LOW      0
`define GPT_IDX_CORE         1
`define GPT_IDX_AUX_HIGH     2
// finest resolution in system clocks, and the divider bits it needs
`define GPT_BASE_CYCLES      4
`define GPT_BASE_BITS        2
// prescaler exponent width and the divider bits above the base stage
`define GPT_PRESCALE_BITS    3
`define GPT_PRESCALE_STAGES  8
// reset values
`define GPT_TIMER_RESET      16'h0000
`define GPT_LATCH_RESET      1'b0

`endif

// ==== design/gpt_pkg.sv ====
// types of the first timer module: modes, sources, triggers, configuration carriers
package gpt_pkg;

  typedef enum logic [1:0] {
    mode_timer,
    mode_gated,
    mode_counter,
    mode_incremental
  } mode_t;

  typedef enum logic [1:0] {
    edge_rise,
    edge_fall,
    edge_both
  } edge_t;

  typedef enum logic [1:0] {
    aux_normal,
    aux_capture,
    aux_reload
  } aux_func_t;

  typedef enum logic [1:0] {
    src_own,
    src_toggle,
    src_core_wrap
  } aux_src_t;

  typedef enum logic [1:0] {
    trig_pin,
    trig_latch_rise,
    trig_latch_fall,
    trig_latch_any
  } trig_t;

  typedef struct packed {
    logic       run;
    mode_t      mode;
    logic       down;
    logic       ext_dir_en;
    logic [2:0] prescale;
    edge_t      count_edge;
    logic       gate_high;
  } timer_cfg_t;

  typedef struct packed {
    aux_func_t func;
    aux_src_t  src;
    trig_t     trig;
  } aux_cfg_t;

  typedef logic [15:0] word_t;

endpackage

// ==== design/timer_slice.sv ====
// one wrapping up/down timer register with load and wrap pulse
`include "gpt_map.svh"

module timer_slice #(
  parameter int WIDTH = `GPT_TIMER_WIDTH
) (
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  input  wire logic             step,
  input  wire logic             up,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_val,
  output logic      [WIDTH-1:0] value_q,
  output logic                  wrap
);

  // wrap marks the step that passes all ones to zero or zero to all ones; it
  // ignores load so a reload in the wrap cycle cannot loop back into its own trigger
  assign wrap = step & (up ? (&value_q) : ~(|value_q)); // R18

  // load wins over a step in the same cycle
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      value_q <= WIDTH'(`GPT_TIMER_RESET);
    end else if (load) begin
      value_q <= load_val;
    end else if (step) begin
      value_q <= up ? value_q + WIDTH'(1) : value_q - WIDTH'(1); // R18
    end
  end

endmodule

// ==== design/general_purpose_timer_block.sv ====
// first timer module: core timer, two auxiliary timers, toggle latch, capture and reload
//
// Notes on behaviour
// R01: five 16-bit timers in two modules; this block holds the first three.
// R02: each of the three timers picks timer, gated, counter or incremental mode.
// R03: timer mode counts the system clock through a programmable prescaler.
// R04: counter mode counts edges seen on the timer's input pin.
// R05: gated mode counts prescaled clock only while the gate level permits.
// R06: each timer's input pin is its gate or its count clock.
// R07: no timer advances more than once per four system clocks.
// R08: software sets direction; optionally the direction pin flips it at run time.
// R09: incremental mode decodes quadrature phases on input and direction pins.
// R10: core toggle latch inverts on every core timer overflow or underflow.
// R11: the toggle latch state can be driven onto the toggle output pin.
// R12: toggle latch transitions can clock either auxiliary timer.
// R13: an auxiliary timer in capture or reload use stops counting.
// R14: capture use copies the core timer on an input pin trigger.
// R15: reload use loads the core timer on pin or selected latch transition.
// R16: opposite-transition reloads from both auxiliaries alternate, giving continuous pwm.
// R17: a timer can count on another timer's overflow, forming a longer timer.
// R18: timers wrap all ones to zero up, zero to all ones down.
`include "gpt_map.svh"

module general_purpose_timer_block #(
  parameter int WIDTH    = `GPT_TIMER_WIDTH,
  parameter int NTIMERS  = `GPT_NUM_TIMERS
) (
  input  wire logic                       core_clk,
  input  wire logic                       reset_n,
  // pins: index 0 aux low, 1 core, 2 aux high
  input  wire logic [NTIMERS-1:0]         timer_input_pin,
  input  wire logic [NTIMERS-1:0]         direction_input_pin,
  output logic                            toggle_output_pin,
  // configuration
  input  wire gpt_pkg::timer_cfg_t        aux_low_cfg,
  input  wire gpt_pkg::timer_cfg_t        core_cfg,
  input  wire gpt_pkg::timer_cfg_t        aux_high_cfg,
  input  wire gpt_pkg::aux_cfg_t          aux_low_func,
  input  wire gpt_pkg::aux_cfg_t          aux_high_func,
  input  wire logic                       toggle_output_en,
  // software writes to the timers
  input  wire logic [NTIMERS-1:0]         timer_write,
  input  wire logic [WIDTH-1:0]           timer_write_data,
  // state
  output logic [WIDTH-1:0]                aux_low_value,
  output logic [WIDTH-1:0]                core_value,
  output logic [WIDTH-1:0]                aux_high_value,
  output logic                            core_toggle_latch,
  output logic [NTIMERS-1:0]              timer_wrap
);

  localparam int PSB = `GPT_PRESCALE_STAGES;
  localparam int DIVW = `GPT_BASE_BITS + PSB;
  localparam int LOW = `GPT_IDX_AUX_LOW;
  localparam int CORE = `GPT_IDX_CORE;
  localparam int HIGH = `GPT_IDX_AUX_HIGH;

  gpt_pkg::timer_cfg_t cfg [NTIMERS];
  logic [NTIMERS-1:0]  in_meta_q;
  logic [NTIMERS-1:0]  in_sync_q;
  logic [NTIMERS-1:0]  dir_meta_q;
  logic [NTIMERS-1:0]  dir_sync_q;
  logic [NTIMERS-1:0]  in_samp_q;
  logic [NTIMERS-1:0]  dir_samp_q;
  logic [DIVW-1:0]     div_q;
  logic                base_tick;
  logic [NTIMERS-1:0]  pin_evt;
  logic [NTIMERS-1:0]  own_step;
  logic [NTIMERS-1:0]  own_up;
  logic [NTIMERS-1:0]  step;
  logic [NTIMERS-1:0]  load;
  logic [WIDTH-1:0]    load_val [NTIMERS];
  logic [WIDTH-1:0]    value [NTIMERS];
  logic [NTIMERS-1:0]  wrap;
  logic [NTIMERS-1:0]  hw_wrap;
  logic                tl_q;
  logic                out_q;
  logic                tl_rise;
  logic                tl_fall;
  logic                low_trig;
  logic                high_trig;
  logic                low_cap;
  logic                high_cap;
  logic                low_reload;
  logic                high_reload;

  assign cfg[LOW]  = aux_low_cfg;
  assign cfg[CORE] = core_cfg;
  assign cfg[HIGH] = aux_high_cfg;

  // mask of divider stages that must be all ones for a prescale exponent
  function automatic logic [PSB-1:0] ps_mask(input logic [`GPT_PRESCALE_BITS-1:0] ps);
    logic [PSB-1:0] m;
    m = '0;
    for (int k = 0; k < PSB; k++) begin
      m[k] = (k < int'(ps));
    end
    return m;
  endfunction

  // input pins are asynchronous: two flops before anything looks at them
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      in_meta_q <= '0;
      in_sync_q <= '0;
    end else begin
      in_meta_q <= timer_input_pin;
      in_sync_q <= in_meta_q;
    end
  end

  // direction pins get the same two-flop synchroniser
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      dir_meta_q <= '0;
      dir_sync_q <= '0;
    end else begin
      dir_meta_q <= direction_input_pin;
      dir_sync_q <= dir_meta_q;
    end
  end

  // free running divider; the low two bits set the four-clock base rate
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + DIVW'(1);
    end
  end

  assign base_tick = &div_q[`GPT_BASE_BITS-1:0]; // R07

  // pins are looked at only on base ticks, so edges closer than four clocks merge
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      in_samp_q <= '0;
    end else if (base_tick) begin
      in_samp_q <= in_sync_q; // R07
    end
  end

  // direction level held from one base tick to the next
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      dir_samp_q <= '0;
    end else if (base_tick) begin
      dir_samp_q <= dir_sync_q;
    end
  end

  // direction pin level as seen by the counting logic
  function automatic logic in_dir(input int idx);
    return dir_samp_q[idx];
  endfunction

  // per-timer mode decode into a step request and a direction
  for (genvar i = 0; i < NTIMERS; i++) begin : g_mode
    logic rise;
    logic fall;
    logic ps_tick;
    logic sw_up;
    logic quad_evt;
    logic quad_up;
    logic mode_step;
    logic mode_up;

    assign rise = base_tick & in_sync_q[i] & ~in_samp_q[i];
    assign fall = base_tick & ~in_sync_q[i] & in_samp_q[i];
    // selected edge of the input pin, as count clock or capture trigger
    assign pin_evt[i] = (rise & (cfg[i].count_edge != gpt_pkg::edge_fall)) |
                        (fall & (cfg[i].count_edge != gpt_pkg::edge_rise)); // R06
    // prescaled clock: base tick and the chosen divider stages all ones
    assign ps_tick = base_tick &
                     (&(div_q[DIVW-1:`GPT_BASE_BITS] | ~ps_mask(cfg[i].prescale))); // R03
    // software direction, optionally flipped by the direction pin
    assign sw_up = ~(cfg[i].down ^ (cfg[i].ext_dir_en & in_dir(i))); // R08
    // quadrature: any phase change counts, a leading a phase counts up
    assign quad_evt = base_tick & ((in_sync_q[i] ^ in_samp_q[i]) | (dir_sync_q[i] ^ dir_samp_q[i])); // R09
    assign quad_up  = (in_sync_q[i] ^ dir_samp_q[i]) ^ cfg[i].down; // R09

    always_comb begin
      mode_step = 1'b0;
      mode_up   = sw_up;
      if (cfg[i].run) begin
        case (cfg[i].mode) // R02
          gpt_pkg::mode_timer:       mode_step = ps_tick; // R03
          gpt_pkg::mode_gated:       mode_step = ps_tick & (in_samp_q[i] == cfg[i].gate_high); // R05
          gpt_pkg::mode_counter:     mode_step = pin_evt[i]; // R04
          gpt_pkg::mode_incremental: begin
            mode_step = quad_evt; // R09
            mode_up   = quad_up;
          end
          default:                   mode_step = 1'b0;
        endcase
      end
    end

    // one driver per bit of the shared step and direction vectors
    assign own_step[i] = mode_step;
    assign own_up[i]   = mode_up;
  end

  // a software write discards the wrapped value, so it is no event; a reload keeps it
  assign hw_wrap = wrap & ~timer_write;

  // toggle latch transitions, known in the cycle of the core wrap
  assign tl_rise = hw_wrap[CORE] & ~tl_q;
  assign tl_fall = hw_wrap[CORE] & tl_q;

  // toggle latch inverts on each core overflow or underflow
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tl_q <= `GPT_LATCH_RESET;
    end else if (hw_wrap[CORE]) begin
      tl_q <= ~tl_q; // R10
    end
  end

  // pin output registered; held low while not enabled
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      out_q <= 1'b0;
    end else begin
      out_q <= tl_q & toggle_output_en; // R11
    end
  end

  // reload trigger chosen per auxiliary timer
  function automatic logic trig_sel(input gpt_pkg::trig_t t, input logic pin, input logic rs,
                                    input logic fl);
    case (t)
      gpt_pkg::trig_pin:        return pin;
      gpt_pkg::trig_latch_rise: return rs;
      gpt_pkg::trig_latch_fall: return fl;
      gpt_pkg::trig_latch_any:  return rs | fl;
      default:                  return 1'b0;
    endcase
  endfunction

  // count source of an auxiliary timer in its normal use
  function automatic logic aux_src_step(input gpt_pkg::aux_src_t s, input logic own, input logic run,
                                        input logic tl_evt, input logic core_wrap);
    case (s)
      gpt_pkg::src_own:       return own;
      gpt_pkg::src_toggle:    return run & tl_evt;
      gpt_pkg::src_core_wrap: return run & core_wrap;
      default:                return 1'b0;
    endcase
  endfunction

  assign low_trig    = trig_sel(aux_low_func.trig, pin_evt[LOW], tl_rise, tl_fall);
  assign high_trig   = trig_sel(aux_high_func.trig, pin_evt[HIGH], tl_rise, tl_fall);
  assign low_cap     = (aux_low_func.func == gpt_pkg::aux_capture) & pin_evt[LOW]; // R14
  assign high_cap    = (aux_high_func.func == gpt_pkg::aux_capture) & pin_evt[HIGH]; // R14
  assign low_reload  = (aux_low_func.func == gpt_pkg::aux_reload) & low_trig; // R15
  assign high_reload = (aux_high_func.func == gpt_pkg::aux_reload) & high_trig; // R15

  // step and load of each timer; software writes take priority over hardware loads
  always_comb begin
    // core timer: its own mode, reloaded from an auxiliary timer
    step[CORE]     = own_step[CORE];
    load[CORE]     = timer_write[CORE] | low_reload | high_reload; // R15
    // opposite latch transitions never coincide, so the two reloads alternate
    load_val[CORE] = timer_write[CORE] ? timer_write_data :
                     low_reload ? value[LOW] : value[HIGH]; // R16

    // auxiliary timers stop while used for capture or reload
    step[LOW]  = (aux_low_func.func == gpt_pkg::aux_normal) &
                 aux_src_step(aux_low_func.src, own_step[LOW], aux_low_cfg.run,
                              tl_rise | tl_fall, hw_wrap[CORE]); // R13 R12 R17
    step[HIGH] = (aux_high_func.func == gpt_pkg::aux_normal) &
                 aux_src_step(aux_high_func.src, own_step[HIGH], aux_high_cfg.run,
                              tl_rise | tl_fall, hw_wrap[CORE]); // R13 R12 R17
    load[LOW]      = timer_write[LOW] | low_cap;
    load_val[LOW]  = timer_write[LOW] ? timer_write_data : value[CORE]; // R14
    load[HIGH]     = timer_write[HIGH] | high_cap;
    load_val[HIGH] = timer_write[HIGH] ? timer_write_data : value[CORE]; // R14
  end

  // the three timers of the first module; the second module lives elsewhere
  for (genvar i = 0; i < NTIMERS; i++) begin : g_timer
    timer_slice #(
      .WIDTH (WIDTH)
    ) u_slice (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .step     (step[i]),
      .up       (own_up[i]),
      .load     (load[i]),
      .load_val (load_val[i]),
      .value_q  (value[i]),
      .wrap     (wrap[i])
    ); // R01
  end

  // outputs
  assign aux_low_value     = value[LOW];
  assign core_value        = value[CORE];
  assign aux_high_value    = value[HIGH];
  assign core_toggle_latch = tl_q;
  assign toggle_output_pin = out_q;
  assign timer_wrap        = hw_wrap;

endmodule

// ==== tb/gpt_pin_model.sv ====
// external pin source: count pulses, gate levels and quadrature phases
module pin_model (
  input  wire logic       core_clk,
  output logic      [2:0] timer_input_pin,
  output logic      [2:0] direction_input_pin
);
  timeunit 1ns;
  timeprecision 100ps;

  // pins start low and are always driven, like a push-pull sensor
  initial begin
    timer_input_pin = 3'h0;
    direction_input_pin = 3'h0;
  end

  // hold each level two base periods, closer edges would merge
  task automatic hold();
    repeat (8) @(posedge core_clk);
    #1;
  endtask

  // set input and direction levels of one timer
  task automatic level(int t, logic a, logic b);
    timer_input_pin[t] = a;
    direction_input_pin[t] = b;
    hold();
  endtask

  // full pulses on the input pin
  task automatic pulse(int t, int n);
    repeat (n) begin
      timer_input_pin[t] = 1'b1;
      hold();
      timer_input_pin[t] = 1'b0;
      hold();
    end
  endtask

  // gray steps of phases a and b, one phase moves per step
  task automatic quad(int t, int n, logic fwd);
    repeat (n) begin
      if ((timer_input_pin[t] ^ direction_input_pin[t]) == fwd) direction_input_pin[t] = ~direction_input_pin[t];
      else timer_input_pin[t] = ~timer_input_pin[t];
      hold();
    end
  endtask
endmodule

// ==== tb/general_purpose_timer_block_properties.sv ====
// checker of port timing of the first timer module
module gpt_checker #(
  parameter int WIDTH   = 16,
  parameter int NTIMERS = 3
) (
  input wire logic                core_clk,
  input wire logic                reset_n,
  input wire logic                toggle_output_pin,
  input wire gpt_pkg::timer_cfg_t core_cfg,
  input wire gpt_pkg::timer_cfg_t aux_high_cfg,
  input wire gpt_pkg::aux_cfg_t   aux_low_func,
  input wire gpt_pkg::aux_cfg_t   aux_high_func,
  input wire logic                toggle_output_en,
  input wire logic [NTIMERS-1:0]  timer_write,
  input wire logic [WIDTH-1:0]    aux_low_value,
  input wire logic [WIDTH-1:0]    core_value,
  input wire logic [WIDTH-1:0]    aux_high_value,
  input wire logic                core_toggle_latch,
  input wire logic [NTIMERS-1:0]  timer_wrap
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  logic       nold;
  logic [1:0] gap_q;

  // reloads may move the core timer off its own steps
  assign nold = aux_low_func.func != gpt_pkg::aux_reload && aux_high_func.func != gpt_pkg::aux_reload;

  // saturating cycles since the last counting change of the core timer
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) gap_q <= 2'h3;
    else if ($changed(core_value) && !$past(timer_write[1])) gap_q <= 2'h0;
    else if (gap_q != 2'h3) gap_q <= gap_q + 2'h1;
  end

  a_pin_follows: assert property (toggle_output_pin == $past(core_toggle_latch & toggle_output_en))
    else $error("toggle pin does not follow latch");
  a_latch_flip: assert property (timer_wrap[1] |=> core_toggle_latch != $past(core_toggle_latch))
    else $error("latch kept state on core wrap");
  a_latch_hold: assert property (!timer_wrap[1] |=> $stable(core_toggle_latch))
    else $error("latch moved without core wrap");
  a_step_gap: assert property ($changed(core_value) && !$past(timer_write[1]) && nold |-> gap_q == 2'h3)
    else $error("core steps closer than four clocks");
  a_wrap_up: assert property (timer_wrap[1] && core_value == '1 && nold && !timer_write[1] |=> core_value == '0)
    else $error("up wrap not to zero");
  a_wrap_down: assert property (timer_wrap[1] && core_value == '0 && nold && !timer_write[1] |=> core_value == '1)
    else $error("down wrap not to all ones");
  a_core_stop: assert property (!core_cfg.run && nold && !timer_write[1] |=> $stable(core_value))
    else $error("stopped core timer moved");
  a_aux_stop: assert property (aux_low_func.func == gpt_pkg::aux_reload && !timer_write[0] |=> $stable(aux_low_value))
    else $error("reload timer counted");
  a_reload_rise: assert property (timer_wrap[1] && aux_low_func.func == gpt_pkg::aux_reload
    && aux_low_func.trig == gpt_pkg::trig_latch_rise && !core_toggle_latch && !timer_write[1]
    |=> core_value == $past(aux_low_value)) else $error("core not reloaded on latch rise");
  a_cascade: assert property (timer_wrap[1] && aux_high_func.src == gpt_pkg::src_core_wrap
    && aux_high_func.func == gpt_pkg::aux_normal && aux_high_cfg.run && !aux_high_cfg.down
    && !aux_high_cfg.ext_dir_en && !timer_write[2] |=> aux_high_value == $past(aux_high_value) + 1'b1)
    else $error("chained timer missed core wrap");

  c_pwm: cover property (timer_wrap[1] && aux_high_func.func == gpt_pkg::aux_reload);
  c_capture: cover property (aux_low_func.func == gpt_pkg::aux_capture && $changed(aux_low_value));
  c_cascade: cover property (timer_wrap[1] && aux_high_func.src == gpt_pkg::src_core_wrap);
endmodule

bind general_purpose_timer_block gpt_checker #(.WIDTH(WIDTH), .NTIMERS(NTIMERS)) i_chk (
  .core_clk, .reset_n, .toggle_output_pin, .core_cfg, .aux_high_cfg, .aux_low_func, .aux_high_func,
  .toggle_output_en, .timer_write, .aux_low_value, .core_value, .aux_high_value, .core_toggle_latch, .timer_wrap
);

// ==== tb/general_purpose_timer_block_bench.sv ====
// self-checking bench of the first timer module
module general_purpose_timer_block_bench;
  timeunit 1ns;
  timeprecision 100ps;
  `define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; $display("[ERR] %0t %h != %h", $time, a, b); end end
  logic                core_clk         = 1'b0;
  logic                reset_n          = 1'b0;
  logic                toggle_output_en = 1'b0;
  logic [2:0]          timer_write      = 3'h0;
  logic [15:0]         timer_write_data = 16'h0000;
  gpt_pkg::timer_cfg_t cfg [3]          = '{default: '0};
  gpt_pkg::aux_cfg_t   aux_low_func     = '0;
  gpt_pkg::aux_cfg_t   aux_high_func    = '0;
  logic [2:0]          timer_input_pin;
  logic [2:0]          direction_input_pin;
  logic                toggle_output_pin;
  logic                core_toggle_latch;
  logic [2:0]          timer_wrap;
  logic [15:0]         val [3];
  logic [15:0]         v;
  logic [15:0]         lo;
  logic                dn;
  logic [2:0]          ps;
  int                  bad_count  = 0;
  int                  num_checks = 0;
  int                  seed       = 47;
  int                  n;
  int                  d;

  general_purpose_timer_block i_dut (
    .core_clk, .reset_n, .timer_input_pin, .direction_input_pin, .toggle_output_pin,
    .aux_low_cfg(cfg[0]), .core_cfg(cfg[1]), .aux_high_cfg(cfg[2]), .aux_low_func, .aux_high_func,
    .toggle_output_en, .timer_write, .timer_write_data, .aux_low_value(val[0]), .core_value(val[1]),
    .aux_high_value(val[2]), .core_toggle_latch, .timer_wrap
  );
  pin_model i_pin (.core_clk, .timer_input_pin, .direction_input_pin);

  // 50 mhz system clock
  always #10 core_clk = ~core_clk;

  // inputs move 1 ns after the edge so sampling never races
  task automatic tick(int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask

  // one-cycle software write, taken at the next edge
  task automatic wr(int t, logic [15:0] dat);
    timer_write[t] = 1'b1;
    timer_write_data = dat;
    tick(1);
    timer_write[t] = 1'b0;
  endtask

  // cycles until the toggle pin changes, bounded
  task automatic measure(output int c);
    logic p;
    p = toggle_output_pin;
    c = 0;
    while (toggle_output_pin === p && c < 2000) begin
      tick(1);
      c++;
    end
  endtask

  function automatic gpt_pkg::timer_cfg_t cf(gpt_pkg::mode_t m, logic down, logic [2:0] pre,
                                             gpt_pkg::edge_t e, logic ext);
    return '{1'b1, m, down, ext, pre, e, 1'b1};
  endfunction

  // value after k steps in the given direction, wrapping
  function automatic logic [15:0] nx(logic [15:0] x, int k, logic down);
    return down ? x - 16'(k) : x + 16'(k);
  endfunction

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // main sequence
  initial begin
    tick(8);
    `CHK({val[0], val[1], val[2], core_toggle_latch, toggle_output_pin, timer_wrap}, 53'h0)
    reset_n = 1'b1;
    tick(2);
    $display("end of reset test");
    // timer mode, random prescale and direction, wrap corners first
    for (int i = 0; i < 6; i++) begin
      ps = (i < 2) ? 3'h0 : 3'($random(seed) & 3);
      dn = (i < 2) ? !i[0] : 1'($random(seed));
      v = (i < 2) ? {16{i[0]}} ^ 16'h0001 : 16'($random(seed));
      cfg[1] = cf(gpt_pkg::mode_timer, dn, ps, gpt_pkg::edge_rise, 1'b0);
      d = core_toggle_latch;
      wr(1, v);
      tick(3 * (4 << ps));
      `CHK(val[1], nx(v, 3, dn))
      `CHK(core_toggle_latch, 1'(d) ^ (dn ? v < 3 : v > 16'hfffc))
    end
    $display("end of timer mode test");
    // direction pin reverses an up-counting timer
    i_pin.level(1, 1'b0, 1'b1);
    cfg[1] = cf(gpt_pkg::mode_timer, 1'b0, 3'h0, gpt_pkg::edge_rise, 1'b1);
    tick(12);
    wr(1, 16'h0100);
    tick(40);
    `CHK(val[1], 16'h00f6)
    $display("end of direction pin test");
    // gate low holds the timer, gate high lets it count
    cfg[1] = cf(gpt_pkg::mode_gated, 1'b0, 3'h0, gpt_pkg::edge_rise, 1'b0);
    for (int g = 0; g < 2; g++) begin
      toggle_output_en = g[0];
      i_pin.level(1, g[0], 1'b0);
      tick(12);
      wr(1, 16'h0000);
      tick(40);
      `CHK(val[1], 16'(10 * g))
    end
    $display("end of gated test");
    // counter mode, one edge choice per timer
    for (int t = 0; t < 3; t++) begin
      n = 2 + ($random(seed) & 3);
      i_pin.level(t, 1'b0, 1'b0);
      cfg[t] = cf(gpt_pkg::mode_counter, 1'b0, 3'h0, gpt_pkg::edge_t'(t), 1'b0);
      tick(12);
      wr(t, 16'h0000);
      i_pin.pulse(t, n);
      tick(12);
      `CHK(val[t], 16'(t == 2 ? 2 * n : n))
    end
    $display("end of counter test");
    // quadrature forward then back on each timer
    for (int t = 0; t < 3; t++) begin
      cfg[t] = cf(gpt_pkg::mode_incremental, 1'b0, 3'h0, gpt_pkg::edge_rise, 1'b0);
      wr(t, 16'h0000);
      i_pin.quad(t, 7, 1'b1);
      i_pin.quad(t, 3, 1'b0);
      tick(12);
      `CHK(val[t], 16'h0004)
    end
    $display("end of incremental test");
    // stopped core captured by each auxiliary timer, which never counts
    cfg[1].run = 1'b0;
    for (int t = 0; t < 3; t += 2) begin
      v = 16'($random(seed));
      cfg[t] = cf(gpt_pkg::mode_timer, 1'b0, 3'h0, gpt_pkg::edge_rise, 1'b0);
      if (t == 0) aux_low_func.func = gpt_pkg::aux_capture;
      else aux_high_func.func = gpt_pkg::aux_capture;
      wr(1, v);
      wr(t, 16'h1234);
      tick(20);
      `CHK(val[t], 16'h1234)
      i_pin.pulse(t, 1);
      tick(12);
      `CHK(val[t], v)
    end
    // a pin edge on the high auxiliary reloads the stopped core timer
    aux_high_func = '{gpt_pkg::aux_reload, gpt_pkg::src_own, gpt_pkg::trig_pin};
    wr(2, 16'h5a5a ^ v);
    i_pin.pulse(2, 1);
    tick(12);
    `CHK(val[1], 16'h5a5a ^ v)
    $display("end of capture test");
    // pwm from two reloads on opposite latch transitions
    lo = 16'hfff0 | 16'($random(seed) & 15);
    v = 16'hffe0 | 16'($random(seed) & 31);
    aux_low_func = '{gpt_pkg::aux_reload, gpt_pkg::src_own, gpt_pkg::trig_latch_rise};
    aux_high_func = '{gpt_pkg::aux_reload, gpt_pkg::src_own, gpt_pkg::trig_latch_fall};
    wr(0, lo);
    wr(2, v);
    cfg[1] = cf(gpt_pkg::mode_timer, 1'b0, 3'h0, gpt_pkg::edge_rise, 1'b0);
    wr(1, 16'hffff);
    measure(d);
    for (int k = 0; k < 2; k++) begin
      measure(d);
      `CHK(d, 4 * (65536 - (toggle_output_pin ? int'(v) : int'(lo))))
    end
    $display("end of pwm test");
    // core wraps clock both auxiliary timers
    aux_low_func = '{gpt_pkg::aux_normal, gpt_pkg::src_toggle, gpt_pkg::trig_pin};
    aux_high_func = '{gpt_pkg::aux_normal, gpt_pkg::src_core_wrap, gpt_pkg::trig_pin};
    wr(1, 16'h0000);
    wr(0, 16'h0000);
    wr(2, 16'hfffe);
    for (int k = 0; k < 3; k++) begin
      wr(1, 16'hffff);
      tick(8);
    end
    `CHK(val[0], 16'h0003)
    `CHK(val[2], 16'h0001)
    $display("end of chaining test");
    final_report();
  end

  // watchdog: the tests need at most about 1600 clocks
  initial begin
    #400us;
    bad_count++;
    final_report();
  end
endmodule
